// ---- hdl/ssp_defs.svh ----
// Constants for the synchronous serial port: field limits, pin bit positions, sizes.
// Assumes inclusion by the package and by the design modules, in any order.
`ifndef SSP_DEFS_SVH
`define SSP_DEFS_SVH
`define SSP_WORD_W 16
`define SSP_FIFO_DEPTH 8
`define SSP_LEN_M1_MIN 4'h3
`define SSP_LEN_M1_MAX 4'hf
`define SSP_PIN_SCLK 2
`define SSP_PIN_FRAME 1
`define SSP_PIN_RXD 0
`define SSP_PRE_MIN 8'h01
`endif

// ---- hdl/ssp_pkg.sv ----
// Types shared by the synchronous serial port modules.
// Assumes ssp_defs.svh is on the include path.
`include "ssp_defs.svh"
package ssp_pkg;
  typedef enum logic [1:0] {
    SSP_FMT_SPI = 2'b00,
    SSP_FMT_CMD = 2'b01,
    SSP_FMT_PULSE = 2'b10
  } ssp_fmt_t;

  typedef enum logic [1:0] {
    SSP_ST_IDLE = 2'b00,
    SSP_ST_LEAD = 2'b01,
    SSP_ST_SHIFT = 2'b10
  } ssp_mst_t;

  typedef struct packed {
    logic master;
    logic out_dis;
    ssp_fmt_t fmt;
    logic [3:0] len_m1;
    logic [7:0] prescale;
    logic [7:0] divider;
  } ssp_cfg_t;

  typedef struct packed {
    logic sclk;
    logic frame;
    logic txd;
    logic txd_oe;
    logic ctl_oe;
  } ssp_pins_t;

  typedef struct packed {
    logic [2:0] s1;
    logic [2:0] s2;
    logic [2:0] s3;
    ssp_mst_t st;
    logic [7:0] pre_cnt;
    logic [7:0] div_cnt;
    logic active;
    logic [4:0] cnt;
    logic [15:0] sh_out;
    logic [15:0] sh_in;
    logic rx_push;
    logic [15:0] rx_word;
    ssp_pins_t pins;
  } ssp_core_st_t;
endpackage

// ---- hdl/ssp_fifo.sv ----
// Word FIFO with valid/ready on both sides and registered full/empty flags.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps
`include "ssp_defs.svh"
module ssp_fifo #(
  parameter int W = `SSP_WORD_W,
  parameter int DEPTH = `SSP_FIFO_DEPTH
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
  begin : g_bad_depth
    $error("ssp_fifo depth must be a power of two, at least 2");
  end

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
    logic nfull;
    logic nempty;
  } ssp_fifo_st_t;

  ssp_fifo_st_t q;
  ssp_fifo_st_t d;
  logic push;
  logic pop;

  assign push = in_valid_i && q.nfull;
  assign pop = out_ready_i && q.nempty;
  // Room flag is kept in its own flop so the ready output needs no gate
  assign in_ready_o = q.nfull;
  assign out_valid_o = q.nempty;
  assign out_data_o = q.mem[q.rd];

  always_comb
  begin
    d = q;
    if (push)
    begin
      d.mem[q.wr] = in_data_i;
      d.wr = q.wr + 1'b1;
    end
    if (pop)
    begin
      d.rd = q.rd + 1'b1;
    end
    d.cnt = q.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    d.nfull = (d.cnt != (AW+1)'(DEPTH));
    d.nempty = (d.cnt != '0);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      q <= '0;
      q.nfull <= 1'b1;
    end
    else
      q <= d;
  end

  // Flags agree with the fill count, which never passes the depth
  AST_FIFO_LEVEL: assert property (@(posedge clk_i) disable iff (rst_i)
    (q.cnt <= (AW+1)'(DEPTH)) && (q.nfull == (q.cnt != (AW+1)'(DEPTH)))
    && (q.nempty == (q.cnt != '0)))
    else $error("fifo flags disagree with fill level");
endmodule // ssp_fifo

// ---- hdl/ssp_core.sv ----
// Synchronous serial port: master or slave, three frame formats, 4..16 bit frames.
// Assumes configuration held stable while a frame runs; pins come from another domain.
`timescale 1ns/10ps
`include "ssp_defs.svh"
module ssp_core #(
  parameter int DEPTH = `SSP_FIFO_DEPTH
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire ssp_pkg::ssp_cfg_t cfg_i,
  input wire logic tx_valid_i,
  output logic tx_ready_o,
  input wire logic [15:0] tx_data_i,
  output logic rx_valid_o,
  input wire logic rx_ready_i,
  output logic [15:0] rx_data_o,
  input wire logic sclk_pin_i,
  input wire logic frame_pin_i,
  input wire logic rxd_i,
  output logic sclk_o,
  output logic frame_o,
  output logic ctl_oe_o,
  output logic txd_o,
  output logic txd_oe_o
);
  if (DEPTH < 2)
  begin : g_bad_depth
    $error("ssp_core needs at least two FIFO entries");
  end

  ssp_pkg::ssp_core_st_t q;
  ssp_pkg::ssp_core_st_t d;
  logic tx_ok;
  logic [15:0] tx_word;
  logic tx_pop;
  logic rx_room;
  logic [3:0] len_m1;
  logic [4:0] total_m1;
  logic [7:0] pre_lim;
  logic half_tick;
  logic rise_ev;
  logic fall_ev;
  logic start_ev;
  logic rx_phase;
  logic is_cmd;
  logic is_pulse;

  ssp_fifo #(.W(`SSP_WORD_W), .DEPTH(DEPTH)) u_tx_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_valid_i(tx_valid_i),
    .in_ready_o(tx_ready_o),
    .in_data_i(tx_data_i),
    .out_valid_o(tx_ok),
    .out_ready_i(tx_pop),
    .out_data_o(tx_word)
  );

  ssp_fifo #(.W(`SSP_WORD_W), .DEPTH(DEPTH)) u_rx_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_valid_i(q.rx_push),
    .in_ready_o(rx_room),
    .in_data_i(q.rx_word),
    .out_valid_o(rx_valid_o),
    .out_ready_i(rx_ready_i),
    .out_data_o(rx_data_o)
  );

  assign is_cmd = (cfg_i.fmt == ssp_pkg::SSP_FMT_CMD);
  assign is_pulse = (cfg_i.fmt == ssp_pkg::SSP_FMT_PULSE);
  // Out-of-range lengths are clamped to the shortest legal frame
  assign len_m1 = (cfg_i.len_m1 < `SSP_LEN_M1_MIN) ? `SSP_LEN_M1_MIN : cfg_i.len_m1;
  // Command format: command bits out, then the same count of response bits in
  assign total_m1 = is_cmd ? {len_m1, 1'b1} : {1'b0, len_m1};
  assign rx_phase = !is_cmd || (q.cnt > {1'b0, len_m1});
  assign pre_lim = (cfg_i.prescale < `SSP_PRE_MIN) ? 8'h00 : cfg_i.prescale - 8'h01;
  assign half_tick = cfg_i.master && (q.pre_cnt == pre_lim) && (q.div_cnt == cfg_i.divider);
  assign tx_pop = start_ev && tx_ok;

  always_comb
  begin
    d = q;
    rise_ev = 1'b0;
    fall_ev = 1'b0;
    start_ev = 1'b0;
    d.rx_push = 1'b0;
    d.s1 = {sclk_pin_i, frame_pin_i, rxd_i};
    d.s2 = q.s1;
    d.s3 = q.s2;
    // Prescaler then bit-rate divider make the half-bit enable
    if (!cfg_i.master || q.pre_cnt == pre_lim)
    begin
      d.pre_cnt = 8'h00;
      d.div_cnt = (!cfg_i.master || q.div_cnt == cfg_i.divider) ? 8'h00 : q.div_cnt + 8'h01;
    end
    else
    begin
      d.pre_cnt = q.pre_cnt + 8'h01;
    end
    if (cfg_i.master)
    begin
      case (q.st)
        ssp_pkg::SSP_ST_IDLE:
        begin
          d.pins.sclk = 1'b0;
          d.pins.frame = !is_pulse;
          // Start only with a word to send and room for the answer
          if (half_tick && tx_ok && rx_room && !q.rx_push)
          begin
            start_ev = 1'b1;
            d.st = ssp_pkg::SSP_ST_LEAD;
            d.pins.frame = is_pulse;
          end
        end
        ssp_pkg::SSP_ST_LEAD:
        begin
          if (half_tick)
          begin
            d.st = ssp_pkg::SSP_ST_SHIFT;
            d.pins.frame = 1'b0;
          end
        end
        ssp_pkg::SSP_ST_SHIFT:
        begin
          if (half_tick && !q.pins.sclk)
          begin
            rise_ev = 1'b1;
            d.pins.sclk = 1'b1;
          end
          else if (half_tick)
          begin
            fall_ev = 1'b1;
            d.pins.sclk = 1'b0;
            // Clock stops after each frame's closing falling edge
            if (!q.active)
            begin
              d.st = ssp_pkg::SSP_ST_IDLE;
              d.pins.frame = !is_pulse;
            end
          end
        end
        default:
        begin
          d.st = ssp_pkg::SSP_ST_IDLE;
        end
      endcase
    end
    else
    begin
      // Slave follows the synchronised clock and frame pins
      d.st = ssp_pkg::SSP_ST_IDLE;
      d.pins.sclk = 1'b0;
      d.pins.frame = 1'b0;
      rise_ev = q.s2[`SSP_PIN_SCLK] && !q.s3[`SSP_PIN_SCLK];
      fall_ev = !q.s2[`SSP_PIN_SCLK] && q.s3[`SSP_PIN_SCLK];
      if (is_pulse)
        start_ev = rise_ev && !q.active && q.s2[`SSP_PIN_FRAME];
      else
        start_ev = q.s3[`SSP_PIN_FRAME] && !q.s2[`SSP_PIN_FRAME];
      if (start_ev)
        rise_ev = 1'b0;
      if (!is_pulse && q.s2[`SSP_PIN_FRAME])
        d.active = 1'b0;
    end
    if (start_ev)
    begin
      d.active = 1'b1;
      d.cnt = 5'h00;
      d.sh_in = 16'h0000;
      d.sh_out = (tx_ok ? tx_word : 16'h0000) << (4'hf - len_m1);
      d.pins.txd = d.sh_out[15];
    end
    else if (rise_ev && q.active)
    begin
      // Receive and transmit share every bit clock, except command format, where receive takes only the bits after the command
      if (rx_phase)
        d.sh_in = {q.sh_in[14:0], q.s2[`SSP_PIN_RXD]};
      d.cnt = q.cnt + 5'h01;
      if (q.cnt == total_m1)
      begin
        d.active = 1'b0;
        d.rx_push = 1'b1;
        d.rx_word = d.sh_in;
      end
    end
    else if (fall_ev && q.active)
    begin
      d.sh_out = {q.sh_out[14:0], 1'b0};
      d.pins.txd = (is_cmd && q.cnt > {1'b0, len_m1}) ? 1'b0 : d.sh_out[15];
    end
    d.pins.ctl_oe = cfg_i.master;
    if (cfg_i.master)
      d.pins.txd_oe = 1'b1;
    else
      d.pins.txd_oe = !cfg_i.out_dis && (is_pulse ? q.active : !q.s2[`SSP_PIN_FRAME]);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      q <= '0;
      q.pins.frame <= 1'b1;
    end
    else
      q <= d;
  end

  assign sclk_o = q.pins.sclk;
  assign frame_o = q.pins.frame;
  assign ctl_oe_o = q.pins.ctl_oe;
  assign txd_o = q.pins.txd;
  assign txd_oe_o = q.pins.txd_oe;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  AST_PULSE_CLK_LOW: assert property (cfg_i.master && is_pulse && frame_o |-> !sclk_o)
    else $error("frame pulse overlaps a clock high phase");
  AST_FRAME_BITS: assert property (q.rx_push |-> $past(q.cnt) == total_m1)
    else $error("stored word does not close a full frame");
  AST_RX_WIDTH: assert property (q.rx_push |-> (q.rx_word >> ({1'b0, len_m1} + 5'h01)) == 16'h0)
    else $error("received word has bits above the frame length");
  AST_TX_STABLE: assert property (cfg_i.master && $rose(sclk_o) |-> $stable(txd_o))
    else $error("data changed on the sampling edge");
  AST_SLAVE_NO_DRIVE: assert property (!cfg_i.master ##1 !cfg_i.master |-> !ctl_oe_o)
    else $error("slave drives clock or frame");
  AST_OUT_OFF: assert property (!cfg_i.master && cfg_i.out_dis ##1
    !cfg_i.master && cfg_i.out_dis |-> !txd_oe_o)
    else $error("disabled slave drives its data output");
  AST_RATE: assert property ($changed(sclk_o) && cfg_i.master |-> $past(half_tick))
    else $error("serial clock moved off the divided enable");
  AST_RX_STORED: assert property (q.rx_push && rx_room |-> ##[1:2] rx_valid_o)
    else $error("received word did not reach the receive FIFO");
  // The frame pin may only leave idle when a word was waiting one cycle earlier
  AST_START_WORD: assert property (cfg_i.master &&
    (is_pulse ? $rose(frame_o) : $fell(frame_o)) |-> $past(tx_ok))
    else $error("master began a frame with nothing to send");
endmodule // ssp_core

// ---- tb/ssp_peer_model.sv ----
// Serial peripheral on the far side of a master port: captures txd, replies on rxd.
// Assumes clock idle low, sampling on the rise, and the master's half bit >= 4 clocks.
`timescale 1ns/10ps
module ssp_peer_model (
  input wire logic clk_i,
  input wire ssp_pkg::ssp_fmt_t fmt_i,
  input wire logic [4:0] len_i,
  input wire logic sclk_i,
  input wire logic frame_i,
  input wire logic txd_i,
  output logic rxd_o,
  output logic done_o,
  output logic [15:0] cap_o
);
  logic sc_q = 1'b0;
  logic fr_q = 1'b1;
  logic [5:0] cnt = 6'h00;
  logic [5:0] idx;
  logic [5:0] off;
  logic [7:0] n = 8'h00;
  logic [15:0] rep;
  assign rep = 16'hc35a ^ {8'h00, n};
  assign off = (fmt_i == ssp_pkg::SSP_FMT_CMD) ? {1'b0, len_i} : 6'h00;
  initial
  begin
    rxd_o = 1'b0;
    done_o = 1'b0;
    cap_o = 16'h0000;
  end
  always @(posedge clk_i)
  begin
    sc_q <= sclk_i;
    fr_q <= frame_i;
    done_o <= 1'b0;
    idx = cnt;
    if ((fmt_i == ssp_pkg::SSP_FMT_PULSE) ? (frame_i && !fr_q) : (!frame_i && fr_q))
      idx = 6'h00;
    else if (sclk_i && !sc_q)
    begin
      if (cnt < {1'b0, len_i})
        cap_o <= {cap_o[14:0], txd_i};
      idx = cnt + 6'h01;
      if (idx == off + {1'b0, len_i})
      begin
        done_o <= 1'b1;
        n <= n + 8'h01;
      end
    end
    cnt <= idx;
    // Outside the reply phase the line toggles so stale bits never look valid
    if (idx >= off && idx < off + {1'b0, len_i})
      rxd_o <= rep[len_i - 5'h01 - 5'(idx - off)];
    else
      rxd_o <= ~rxd_o;
  end
endmodule // ssp_peer_model

// ---- tb/tb_top.sv ----
// Self-checking bench for ssp_core: master frames in every format, then slave receive.
// Assumes ssp_peer_model as the far side while the port is master.
`timescale 1ns/10ps
module tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  ssp_pkg::ssp_cfg_t cfg = '0;
  logic tx_valid_i = 1'b0;
  logic [15:0] tx_data_i = 16'h0000;
  logic rx_ready_i = 1'b0;
  logic sclk_pin_i = 1'b0;
  logic frame_pin_i = 1'b1;
  logic tb_rxd = 1'b0;
  logic tx_ready_o, rx_valid_o, sclk_o, frame_o, ctl_oe_o, txd_o, txd_oe_o;
  logic [15:0] rx_data_o, mdl_cap, mask;
  logic mdl_rxd, mdl_done, saw_full, rdy_en = 1'b1;
  logic [15:0] lfsr = 16'h003e;
  logic [7:0] n_rep = 8'h00, hi = 8'h00, half;
  logic [15:0] q_tx[$], q_rx[$];
  int n_errors = 0, cmp_count = 0;
  always #10 clk_i = ~clk_i;
  ssp_core ssp_core_inst (.clk_i(clk_i), .rst_i(rst_i), .cfg_i(cfg), .tx_valid_i(tx_valid_i),
    .tx_ready_o(tx_ready_o), .tx_data_i(tx_data_i), .rx_valid_o(rx_valid_o),
    .rx_ready_i(rx_ready_i), .rx_data_o(rx_data_o), .sclk_pin_i(sclk_pin_i),
    .frame_pin_i(frame_pin_i), .rxd_i(cfg.master ? mdl_rxd : tb_rxd), .sclk_o(sclk_o),
    .frame_o(frame_o), .ctl_oe_o(ctl_oe_o), .txd_o(txd_o), .txd_oe_o(txd_oe_o));
  ssp_peer_model ssp_peer_model_inst (.clk_i(clk_i), .fmt_i(cfg.fmt),
    .len_i({1'b0, cfg.len_m1} + 5'h01), .sclk_i(sclk_o), .frame_i(frame_o), .txd_i(txd_o),
    .rxd_o(mdl_rxd), .done_o(mdl_done), .cap_o(mdl_cap));
  function automatic logic [15:0] nxt(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: word %h, wanted %h", $time, got, exp);
    end
  endtask
  task automatic cmp1(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: flag %b, wanted %b", $time, got, exp);
    end
  endtask
  task automatic close_out;
    $display("mismatches %0d, comparisons %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // Random receiver stalls
  always @(posedge clk_i)
  begin
    lfsr <= nxt(lfsr);
    #1 rx_ready_i = rdy_en & lfsr[3];
  end
  always @(posedge clk_i)
  begin
    if (mdl_done === 1'b1)
      cmp16(mdl_cap & mask, q_tx.size() > 0 ? q_tx.pop_front() : ~mdl_cap);
    if (rx_valid_o === 1'b1 && rx_ready_i === 1'b1)
      cmp16(rx_data_o, q_rx.size() > 0 ? q_rx.pop_front() : ~rx_data_o);
    if (sclk_o === 1'b1)
      hi <= hi + 8'h01;
    else if (hi != 8'h00)
    begin
      cmp16({8'h00, hi}, {8'h00, half});
      hi <= 8'h00;
    end
  end
  task automatic put(input logic [15:0] w);
    tx_valid_i = 1'b1;
    tx_data_i = w;
    q_tx.push_back(w & mask);
    q_rx.push_back((16'hc35a ^ {8'h00, n_rep}) & mask);
    n_rep++;
    @(posedge clk_i);
    for (int k = 0; tx_ready_o !== 1'b1 && k < 9000; k++)
    begin
      saw_full = 1'b1;
      @(posedge clk_i);
    end
    cmp1(tx_ready_o, 1'b1);
    #1;
  endtask
  task automatic run(input logic [1:0] f, input logic [3:0] l, input logic stall);
    half = (8'h02 + f) * 8'h02;
    mask = 16'hffff >> (4'hf - l);
    // Slow enough for any peripheral on the bench
    cfg = '{master: 1'b1, out_dis: 1'b0, fmt: ssp_pkg::ssp_fmt_t'(f), len_m1: l,
      prescale: 8'h02 + f, divider: 8'h01};
    rdy_en = !stall;
    saw_full = 1'b0;
    tick(2);
    cmp1(ctl_oe_o, 1'b1);
    repeat (12) put(lfsr);
    tx_valid_i = 1'b0;
    cmp1(saw_full, 1'b1);
    if (stall)
    begin
      // Long enough for eight frames of the slowest setting to finish
      tick(2400);
      cmp16(16'(q_tx.size()), 16'h0004);
      rdy_en = 1'b1;
    end
    for (int k = 0; (q_tx.size() + q_rx.size()) > 0 && k < 20000; k++)
      tick(1);
    cmp16(16'(q_tx.size() + q_rx.size()), 16'h0000);
    tick(30);
    cmp1(sclk_o, 1'b0);
    cmp1(frame_o, f != 2'h2);
  endtask
  task automatic slave(input logic dis, input logic [7:0] w, input logic [1:0] f);
    cfg = '{master: 1'b0, out_dis: dis, fmt: ssp_pkg::ssp_fmt_t'(f), len_m1: 4'h7,
      prescale: 8'h02, divider: 8'h01};
    mask = 16'h00ff;
    frame_pin_i = (f != 2'h2);
    tick(4);
    q_rx.push_back({8'h00, w});
    // Frame pulse: one clock rise with the frame pin high opens the frame
    if (f == 2'h2)
    begin
      frame_pin_i = 1'b1;
      tick(5);
      sclk_pin_i = 1'b1;
      tick(5);
      sclk_pin_i = 1'b0;
    end
    frame_pin_i = 1'b0;
    tick(6);
    cmp1(txd_oe_o, !dis);
    cmp1(ctl_oe_o, 1'b0);
    // Command format: the first eight clocks carry the command, not the answer
    for (int i = (f == 2'h1) ? 15 : 7; i >= 0; i--)
    begin
      tb_rxd = (i > 7) ? lfsr[0] : w[i];
      tick(5);
      sclk_pin_i = 1'b1;
      tick(5);
      sclk_pin_i = 1'b0;
    end
    tick(5);
    frame_pin_i = (f != 2'h2);
    for (int k = 0; q_rx.size() > 0 && k < 200; k++)
      tick(1);
    cmp16(16'(q_rx.size()), 16'h0000);
  endtask
  initial
  begin
    #1_000_000;
    n_errors++;
    close_out();
  end
  initial
  begin
    tick(6);
    rst_i = 1'b0;
    tick(2);
    for (int f = 0; f < 3; f++)
    begin
      run(2'(f), 4'h3, 1'b0);
      run(2'(f), 4'hf, 1'b1);
    end
    slave(1'b0, lfsr[7:0], 2'h0);
    slave(1'b1, 8'ha6, 2'h1);
    slave(1'b0, lfsr[15:8], 2'h2);
    close_out();
  end
endmodule // tb_top
